//--- verilog/tmc_pkg.sv
// Contract
// - timer 1 overflow sets its flag; vectoring to its service routine clears it.
// - timer 0 overflow sets its flag; vectoring to its service routine clears it.
// - timer 1 counts only while its run bit is one.
// - timer 0 counts only while its run bit is one.
// - ext irq 1 flag set by falling edge or low level on its pin.
// - ext irq 0 flag set by falling edge or low level on its pin.
// - vectoring clears ext irq flag only in edge mode; level mode follows pin.
// - ext irq 1 trigger type one selects edge, zero selects low level.
// - ext irq 0 trigger type one selects edge, zero selects low level.
// - timer 2 overflow sets its flag unless a baud select bit is one; software clears.
// - enabled trigger pin falling edge causing capture or reload sets external flag.
// - receive baud select picks timer 2 overflows, else timer 1 overflows.
// - transmit baud select picks timer 2 overflows, else timer 1 overflows.
// - trigger pin acts only with external enable and no baud use.
// - timer 2 counts while its run bit is one, else holds apart from trigger pin reloads.
// - timer 2 counter select picks count pin events, else core clock.
// - capture select captures on trigger edges; else reload on overflow and trigger edges.
// - with a baud select bit set, capture select ignored; always reload on overflow.
// - timer 1 gating set requires ext irq 1 pin high plus run bit.
// - counter mode counts input high-then-low samples; timer mode counts every cycle.
package tmc_pkg;
    localparam logic [7:0] TIMER01_CONTROL_ADDR = 8'h88;
    localparam logic [7:0] TIMER2_CONTROL_ADDR  = 8'hc8;
    localparam logic [7:0] TIMER2_RELOAD_LOW_ADDR  = 8'hca;
    localparam logic [7:0] TIMER2_RELOAD_HIGH_ADDR = 8'hcb;
    localparam logic [7:0] TIMER2_COUNT_LOW_ADDR   = 8'hcc;
    localparam logic [7:0] TIMER2_COUNT_HIGH_ADDR  = 8'hcd;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX   = 16'hffff;
    // timer01_control bits
    localparam int T1_OVF_BIT = 7;
    localparam int T1_RUN_BIT = 6;
    localparam int T0_OVF_BIT = 5;
    localparam int T0_RUN_BIT = 4;
    localparam int X1_REQ_BIT = 3;
    localparam int X1_TYP_BIT = 2;
    localparam int X0_REQ_BIT = 1;
    localparam int X0_TYP_BIT = 0;
    // timer2_control bits
    localparam int T2_OVF_BIT = 7;
    localparam int T2_EXF_BIT = 6;
    localparam int RX_BAUD_BIT = 5;
    localparam int TX_BAUD_BIT = 4;
    localparam int T2_EXEN_BIT = 3;
    localparam int T2_RUN_BIT  = 2;
    localparam int T2_CNT_BIT  = 1;
    localparam int T2_CAP_BIT  = 0;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       bit_wr;
        logic [2:0] bit_sel;
        logic       bit_val;
    } tmc_bus_t;

    typedef struct packed {
        logic t0_vector;
        logic t1_vector;
        logic x0_vector;
        logic x1_vector;
    } tmc_vec_t;

    typedef enum logic [2:0] {
        T2_IDLE    = 3'b001,
        T2_CAPTURE = 3'b010,
        T2_RELOAD  = 3'b100
    } tmc_t2act_t;
endpackage

//--- verilog/tmc_timer_ctrl.sv
module tmc_timer_ctrl (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire tmc_pkg::tmc_bus_t i_bus,
    output logic [7:0]            o_rdata,
    input  wire tmc_pkg::tmc_vec_t i_vec,
    input  wire logic             i_t0_overflow,
    input  wire logic             i_t1_overflow,
    input  wire logic             i_timer1_gating,
    input  wire logic             i_ext_irq0_pin,
    input  wire logic             i_ext_irq1_pin,
    input  wire logic             i_timer2_trigger_pin,
    input  wire logic             i_timer2_count_pin,
    output logic                  o_t0_run,
    output logic                  o_t1_run,
    output logic                  o_rx_baud_tick,
    output logic                  o_tx_baud_tick,
    output logic [15:0]           o_timer2_count
);
    logic [7:0]  tc01_r;
    logic [7:0]  tc2_r;
    logic [15:0] t2cnt_r;
    logic [15:0] rcap_r;
    logic [7:0]  rdata_r;
    logic [2:0]  x0_sync_r;
    logic [2:0]  x1_sync_r;
    logic [2:0]  tx_sync_r;
    logic [2:0]  cp_sync_r;

    // two sync flops, third for edge detect
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            x0_sync_r <= 3'b111;
            x1_sync_r <= 3'b111;
            tx_sync_r <= 3'b111;
            cp_sync_r <= 3'b111;
        end else begin
            x0_sync_r <= {x0_sync_r[1:0], i_ext_irq0_pin};
            x1_sync_r <= {x1_sync_r[1:0], i_ext_irq1_pin};
            tx_sync_r <= {tx_sync_r[1:0], i_timer2_trigger_pin};
            cp_sync_r <= {cp_sync_r[1:0], i_timer2_count_pin};
        end
    end

    wire x0_lvl  = x0_sync_r[1];
    wire x1_lvl  = x1_sync_r[1];
    wire x0_fall = x0_sync_r[2] & ~x0_sync_r[1];
    wire x1_fall = x1_sync_r[2] & ~x1_sync_r[1];
    wire tx_fall = tx_sync_r[2] & ~tx_sync_r[1];
    wire cp_fall = cp_sync_r[2] & ~cp_sync_r[1];

    wire wr_tc01 = i_bus.wr && (i_bus.addr == tmc_pkg::TIMER01_CONTROL_ADDR);
    wire wr_tc2  = i_bus.wr && (i_bus.addr == tmc_pkg::TIMER2_CONTROL_ADDR);
    wire wr_rl   = i_bus.wr && (i_bus.addr == tmc_pkg::TIMER2_RELOAD_LOW_ADDR);
    wire wr_rh   = i_bus.wr && (i_bus.addr == tmc_pkg::TIMER2_RELOAD_HIGH_ADDR);
    wire wr_cl   = i_bus.wr && (i_bus.addr == tmc_pkg::TIMER2_COUNT_LOW_ADDR);
    wire wr_ch   = i_bus.wr && (i_bus.addr == tmc_pkg::TIMER2_COUNT_HIGH_ADDR);
    // bit writes address tc01 at 0x88 and tc2 at 0xc8 only, bit_sel picks the bit
    wire bw_tc01 = i_bus.bit_wr && (i_bus.addr == tmc_pkg::TIMER01_CONTROL_ADDR);
    wire bw_tc2  = i_bus.bit_wr && (i_bus.addr == tmc_pkg::TIMER2_CONTROL_ADDR);

    // software image of each control register after byte or bit write
    logic [7:0] sw01;
    logic [7:0] sw2;
    logic [7:0] m01;
    logic [7:0] m2;
    always_comb begin
        m01 = 8'h00;
        m2  = 8'h00;
        sw01 = tc01_r;
        sw2  = tc2_r;
        if (wr_tc01) begin
            sw01 = i_bus.wdata;
            m01  = 8'hff;
        end else if (bw_tc01) begin
            sw01[i_bus.bit_sel] = i_bus.bit_val;
            m01[i_bus.bit_sel]  = 1'b1;
        end
        if (wr_tc2) begin
            sw2 = i_bus.wdata;
            m2  = 8'hff;
        end else if (bw_tc2) begin
            sw2[i_bus.bit_sel] = i_bus.bit_val;
            m2[i_bus.bit_sel]  = 1'b1;
        end
    end

    wire rx_baud = tc2_r[tmc_pkg::RX_BAUD_BIT];
    wire tx_baud = tc2_r[tmc_pkg::TX_BAUD_BIT];
    wire baud    = rx_baud | tx_baud;
    wire exen    = tc2_r[tmc_pkg::T2_EXEN_BIT];
    wire t2_run  = tc2_r[tmc_pkg::T2_RUN_BIT];
    wire t2_tick = t2_run & (tc2_r[tmc_pkg::T2_CNT_BIT] ? cp_fall : 1'b1);
    wire t2_ovf  = t2_tick & (t2cnt_r == tmc_pkg::COUNT_MAX);
    wire trig    = exen & ~baud & tx_fall;
    wire cap_mode = tc2_r[tmc_pkg::T2_CAP_BIT] & ~baud;

    tmc_pkg::tmc_t2act_t act;
    assign act = (trig & cap_mode)             ? tmc_pkg::T2_CAPTURE :
                 ((trig | t2_ovf) & ~cap_mode) ? tmc_pkg::T2_RELOAD :
                 tmc_pkg::T2_IDLE;

    // hardware set terms, set wins over any clear
    wire x0_edge_mode = tc01_r[tmc_pkg::X0_TYP_BIT];
    wire x1_edge_mode = tc01_r[tmc_pkg::X1_TYP_BIT];
    wire x0_set = x0_edge_mode ? x0_fall : ~x0_lvl;
    wire x1_set = x1_edge_mode ? x1_fall : ~x1_lvl;

    logic [7:0] tc01_nxt;
    logic [7:0] tc2_nxt;
    always_comb begin
        tc01_nxt = sw01;
        if (i_vec.t1_vector && !m01[tmc_pkg::T1_OVF_BIT]) tc01_nxt[tmc_pkg::T1_OVF_BIT] = 1'b0;
        if (i_vec.t0_vector && !m01[tmc_pkg::T0_OVF_BIT]) tc01_nxt[tmc_pkg::T0_OVF_BIT] = 1'b0;
        // level mode: flag tracks pin, no clear on vector
        if (!x1_edge_mode) tc01_nxt[tmc_pkg::X1_REQ_BIT] = ~x1_lvl;
        else if (i_vec.x1_vector && !m01[tmc_pkg::X1_REQ_BIT]) tc01_nxt[tmc_pkg::X1_REQ_BIT] = 1'b0;
        if (!x0_edge_mode) tc01_nxt[tmc_pkg::X0_REQ_BIT] = ~x0_lvl;
        else if (i_vec.x0_vector && !m01[tmc_pkg::X0_REQ_BIT]) tc01_nxt[tmc_pkg::X0_REQ_BIT] = 1'b0;
        if (i_t1_overflow) tc01_nxt[tmc_pkg::T1_OVF_BIT] = 1'b1;
        if (i_t0_overflow) tc01_nxt[tmc_pkg::T0_OVF_BIT] = 1'b1;
        if (x1_set) tc01_nxt[tmc_pkg::X1_REQ_BIT] = 1'b1;
        if (x0_set) tc01_nxt[tmc_pkg::X0_REQ_BIT] = 1'b1;
        tc2_nxt = sw2;
        if (t2_ovf && !baud) tc2_nxt[tmc_pkg::T2_OVF_BIT] = 1'b1;
        if (trig) tc2_nxt[tmc_pkg::T2_EXF_BIT] = 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tc01_r <= tmc_pkg::REG_RESET;
            tc2_r  <= tmc_pkg::REG_RESET;
        end else begin
            tc01_r <= tc01_nxt;
            tc2_r  <= tc2_nxt;
        end
    end

    logic [15:0] t2cnt_nxt;
    logic [15:0] rcap_nxt;
    always_comb begin
        t2cnt_nxt = t2cnt_r;
        rcap_nxt  = rcap_r;
        if (wr_rl) rcap_nxt[7:0]  = i_bus.wdata;
        if (wr_rh) rcap_nxt[15:8] = i_bus.wdata;
        if (wr_cl) t2cnt_nxt[7:0]  = i_bus.wdata;
        if (wr_ch) t2cnt_nxt[15:8] = i_bus.wdata;
        if (t2_tick) t2cnt_nxt = t2cnt_r + 16'h0001;
        case (act)
            tmc_pkg::T2_CAPTURE: rcap_nxt  = t2cnt_r;
            tmc_pkg::T2_RELOAD:  t2cnt_nxt = rcap_r;
            default: ;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            t2cnt_r <= tmc_pkg::COUNT_RESET;
            rcap_r  <= tmc_pkg::COUNT_RESET;
        end else begin
            t2cnt_r <= t2cnt_nxt;
            rcap_r  <= rcap_nxt;
        end
    end

    logic [7:0] rmux;
    always_comb begin
        if (i_bus.addr == tmc_pkg::TIMER01_CONTROL_ADDR) rmux = tc01_r;
        else if (i_bus.addr == tmc_pkg::TIMER2_CONTROL_ADDR) rmux = tc2_r;
        else if (i_bus.addr == tmc_pkg::TIMER2_RELOAD_LOW_ADDR) rmux = rcap_r[7:0];
        else if (i_bus.addr == tmc_pkg::TIMER2_RELOAD_HIGH_ADDR) rmux = rcap_r[15:8];
        else if (i_bus.addr == tmc_pkg::TIMER2_COUNT_LOW_ADDR) rmux = t2cnt_r[7:0];
        else if (i_bus.addr == tmc_pkg::TIMER2_COUNT_HIGH_ADDR) rmux = t2cnt_r[15:8];
        else rmux = 8'h00;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) rdata_r <= 8'h00;
        else if (i_bus.rd) rdata_r <= rmux;
        else rdata_r <= 8'h00;
    end

    assign o_rdata        = rdata_r;
    assign o_t0_run       = tc01_r[tmc_pkg::T0_RUN_BIT];
    assign o_t1_run       = tc01_r[tmc_pkg::T1_RUN_BIT] & (~i_timer1_gating | x1_lvl);
    assign o_rx_baud_tick = rx_baud ? t2_ovf : i_t1_overflow;
    assign o_tx_baud_tick = tx_baud ? t2_ovf : i_t1_overflow;
    assign o_timer2_count = t2cnt_r;
endmodule

//--- tb/tmc_timer_ctrl_asserts.sv
module tmc_timer_ctrl_asserts (
    input wire logic              i_clk,
    input wire logic              i_rst_n,
    input wire tmc_pkg::tmc_bus_t i_bus,
    input wire logic [7:0]        o_rdata,
    input wire logic              i_t1_overflow,
    input wire logic              i_timer1_gating,
    input wire logic              o_t0_run,
    input wire logic              o_t1_run,
    input wire logic              o_rx_baud_tick,
    input wire logic              o_tx_baud_tick,
    input wire logic [15:0]       o_timer2_count
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire bw88 = i_bus.bit_wr && i_bus.addr == 8'h88;
    wire wc8  = i_bus.wr && i_bus.addr == 8'hc8;
    wire idle = !i_bus.wr && !i_bus.bit_wr;
    AST_T0_RUN: assert property (bw88 && i_bus.bit_sel == 3'd4 |=> o_t0_run == $past(i_bus.bit_val))
        else $error("timer 0 run does not follow its bit");
    AST_T1_STOP: assert property (bw88 && i_bus.bit_sel == 3'd6 && !i_bus.bit_val |=> !o_t1_run)
        else $error("timer 1 still runs after stop");
    AST_T1_GATE: assert property (bw88 && i_bus.bit_sel == 3'd6 && i_bus.bit_val ##1 !i_timer1_gating |-> o_t1_run)
        else $error("timer 1 not running with gating off");
    AST_RD_IDLE: assert property (!i_bus.rd |=> o_rdata == 8'h00)
        else $error("read data outside read slot");
    AST_T1_BAUD: assert property (wc8 && i_bus.wdata[5:4] == 2'b00 ##1 1'b1
        |-> o_rx_baud_tick == i_t1_overflow && o_tx_baud_tick == i_t1_overflow)
        else $error("baud ticks not from timer 1");
    AST_T2_HOLD: assert property (wc8 && !i_bus.wdata[2] && i_bus.wdata[5:4] != 2'b00 ##1 idle
        |=> $stable(o_timer2_count))
        else $error("timer 2 moved while stopped");
    AST_T2_COUNT: assert property (wc8 && i_bus.wdata == 8'h04 ##1 (idle && o_timer2_count != 16'hffff)
        |=> o_timer2_count == $past(o_timer2_count) + 16'h0001)
        else $error("timer 2 did not count core cycles");
    AST_T2_BAUD: assert property (wc8 && i_bus.wdata == 8'h34 ##1 (idle && o_timer2_count == 16'hffff)
        |-> o_rx_baud_tick && o_tx_baud_tick)
        else $error("timer 2 overflow missing on baud ticks");
    cover property (wc8 ##1 o_rx_baud_tick);
    cover property (bw88 && i_bus.bit_sel == 3'd6);
    cover property (i_bus.rd ##1 o_rdata != 8'h00);
endmodule
bind tmc_timer_ctrl tmc_timer_ctrl_asserts tmc_timer_ctrl_asserts_i (.i_clk, .i_rst_n, .i_bus, .o_rdata,
    .i_t1_overflow, .i_timer1_gating, .o_t0_run, .o_t1_run, .o_rx_baud_tick, .o_tx_baud_tick, .o_timer2_count);

//--- tb/tmc_pins_model.sv
module tmc_pins_model (
    input  wire logic       i_clk,
    input  wire logic [3:0] i_lvl,
    input  wire logic [1:0] i_fire,
    output logic [3:0]      o_pins = 4'hf,
    output logic [1:0]      o_ovf = 2'b00
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins idle high as with pull-ups; levels move only after an edge
    always @(posedge i_clk) begin
        o_pins <= i_lvl;
        o_ovf  <= i_fire;
    end
endmodule

//--- tb/timer_control_and_ext_irq_flags_bench.sv
module timer_control_and_ext_irq_flags_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic              i_clk = 1'b0;
    logic              i_rst_n = 1'b0;
    tmc_pkg::tmc_bus_t bus = '0;
    tmc_pkg::tmc_vec_t vec = '0;
    logic              gating = 1'b0;
    logic [3:0]        lvl = 4'hf;
    logic [1:0]        fire = 2'b00;
    logic [3:0]        pins;
    logic [1:0]        ovf;
    logic [7:0]        rdata;
    logic              t0_run, t1_run, rx_tick, tx_tick;
    logic [15:0]       cnt, r, c;
    int                errors = 0, n_checks = 0, cycles = 0;
    integer            seed = 32'h8ca4d7de;
    always #4 i_clk = ~i_clk;
    tmc_pins_model tmc_pins_model_i (.i_clk(i_clk), .i_lvl(lvl), .i_fire(fire), .o_pins(pins), .o_ovf(ovf));
    tmc_timer_ctrl tmc_timer_ctrl_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata), .i_vec(vec),
        .i_t0_overflow(ovf[0]), .i_t1_overflow(ovf[1]), .i_timer1_gating(gating), .i_ext_irq0_pin(pins[0]),
        .i_ext_irq1_pin(pins[1]), .i_timer2_trigger_pin(pins[2]), .i_timer2_count_pin(pins[3]),
        .o_t0_run(t0_run), .o_t1_run(t1_run), .o_rx_baud_tick(rx_tick), .o_tx_baud_tick(tx_tick),
        .o_timer2_count(cnt));
    function automatic logic [15:0] t2_next(input logic [15:0] v, input logic [15:0] rl);
        return (v == 16'hffff) ? rl : v + 16'h0001;
    endfunction
    task automatic print_verdict();
        if (errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, default: '0};
        @(posedge i_clk) bus <= '0;
    endtask
    task automatic bw(input logic [7:0] a, input logic [2:0] s, input logic v);
        @(posedge i_clk) bus <= '{addr: a, bit_wr: 1'b1, bit_sel: s, bit_val: v, default: '0};
        @(posedge i_clk) bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk) bus <= '{addr: a, rd: 1'b1, default: '0};
        @(posedge i_clk) bus <= '0;
        #1 chk({8'h00, rdata}, {8'h00, e});
    endtask
    task automatic vp(input logic [3:0] v);
        @(posedge i_clk) vec <= v;
        @(posedge i_clk) vec <= '0;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        w(4);
        i_rst_n <= 1'b1;
        rd(8'h88, 8'h00);
        rd(8'hc8, 8'h00);
        rd(8'h55, 8'h00);
        bw(8'h88, 3'd0, 1'b1);
        bw(8'h88, 3'd2, 1'b1);
        bw(8'h88, 3'd4, 1'b1);
        bw(8'h88, 3'd6, 1'b1);
        @(posedge i_clk) fire <= 2'b11;
        @(posedge i_clk) fire <= 2'b00;
        rd(8'h88, 8'hf5);
        vp(4'b1100);
        rd(8'h88, 8'h55);
        @(posedge i_clk) lvl <= 4'hc;
        w(6);
        rd(8'h88, 8'h5f);
        vp(4'b0011);
        rd(8'h88, 8'h55);
        bw(8'h88, 3'd0, 1'b0);
        vp(4'b0011);
        rd(8'h88, 8'h56);
        @(posedge i_clk) lvl <= 4'hf;
        w(6);
        rd(8'h88, 8'h54);
        r = {1'b0, 15'($random(seed))};
        wr(8'hca, r[7:0]);
        wr(8'hcb, r[15:8]);
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h04);
        w(2);
        #1 chk(cnt, t2_next(t2_next(16'hfffe, r), r));
        rd(8'hc8, 8'h84);
        bw(8'hc8, 3'd7, 1'b0);
        wr(8'hc8, 8'h38);
        #1 c = cnt;
        @(posedge i_clk) lvl <= 4'hb;
        w(6);
        #1 chk(cnt, c);
        rd(8'hc8, 8'h38);
        @(posedge i_clk) lvl <= 4'hf;
        wr(8'hc8, 8'h09);
        w(6);
        @(posedge i_clk) lvl <= 4'hb;
        w(6);
        rd(8'hca, c[7:0]);
        rd(8'hcb, c[15:8]);
        rd(8'hc8, 8'h49);
        wr(8'hc8, 8'h06);
        w(4);
        #1 chk(cnt, c);
        @(posedge i_clk) lvl <= 4'h3;
        w(6);
        #1 chk(cnt, c + 16'h0001);
        wr(8'hc8, 8'h00);
        wr(8'hcc, 8'hff);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h34);
        w(2);
        rd(8'hc8, 8'h34);
        @(posedge i_clk) gating <= 1'b1;
        lvl <= 4'hd;
        w(6);
        #1 chk({15'h0, t1_run}, 16'h0000);
        @(posedge i_clk) lvl <= 4'hf;
        w(6);
        #1 chk({15'h0, t1_run}, 16'h0001);
        bw(8'h88, 3'd6, 1'b0);
        bw(8'h88, 3'd4, 1'b0);
        #1 chk({14'h0, t1_run, t0_run}, 16'h0000);
        print_verdict();
    end
endmodule
